// *** ebu_pkg.sv ***
/*
 * Shared constants, configuration layouts and the sequencer state type of the
 * external bus unit.
 * Assumes a 24-bit CPU address space and a 16-bit CPU data path.
 */
package ebu_pkg;

    localparam int ADDR_W   = 24;
    localparam int DATA_W   = 16;
    localparam int BYTE_W   = 8;
    localparam int WIN_NUM  = 4;
    localparam int CS_NUM   = 4;
    localparam int SEG_LSB  = 16;
    localparam int SEG_W    = ADDR_W - SEG_LSB;
    localparam int PAGE_LSB = 12;
    localparam int PAGE_W   = ADDR_W - PAGE_LSB;
    localparam int CNT_W    = 4;
    localparam int AW_W     = 5;

    // Internal peripheral bus range and the strictly ordered external I/O range.
    localparam logic [ADDR_W-1:0] PERI_LO = 24'h20_0000;
    localparam logic [ADDR_W-1:0] IO_LO   = 24'h20_5800;
    localparam logic [ADDR_W-1:0] IO_HI   = 24'h3F_FFFF;

    localparam logic [2:0] WIN_DEFAULT = 3'h0;
    localparam logic [2:0] WIN_NO_CS   = 3'h4;

    typedef struct packed {
        logic [PAGE_W-1:0] base;
        logic [3:0]        size;
    } ebu_asel_s;

    typedef struct packed {
        logic [1:0]       hold;
        logic [CNT_W-1:0] cmd;
        logic [1:0]       setup;
    } ebu_tcfg_s;

    typedef struct packed {
        logic rdy_pol;
        logic rdy_en;
        logic cs_en;
        logic mux;
        logic bus16;
    } ebu_fcfg_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_CMD  = 3'h3,
        ST_RDY  = 3'h2,
        ST_HOLD = 3'h6,
        ST_PERI = 3'h4
    } ebu_state_e;

    // A window covers 4 KB times two to the power of its size code.
    function automatic logic ebu_win_hit(input logic [ADDR_W-1:0] addr,
                                         input ebu_asel_s         sel);
        logic [PAGE_W-1:0] diff;
        diff = addr[ADDR_W-1:PAGE_LSB] ^ sel.base;
        return (diff >> sel.size) == '0;
    endfunction : ebu_win_hit

endpackage : ebu_pkg

// *** ebu_win_if.sv ***
/*
 * Carrier between the bus sequencer and the address window decoder.
 * Assumes index 0 of the configuration arrays is the default region.
 */
interface ebu_win_if;
    import ebu_pkg::*;

    logic [ADDR_W-1:0]          addr;
    ebu_asel_s [WIN_NUM-1:0]    asel;
    ebu_tcfg_s [WIN_NUM:0]      tcfg;
    ebu_fcfg_s [WIN_NUM:0]      fcfg;
    logic [2:0]                 win;
    ebu_tcfg_s                  sel_t;
    ebu_fcfg_s                  sel_f;

    modport dec (input addr, asel, tcfg, fcfg, output win, sel_t, sel_f);
    modport ctl (output addr, asel, tcfg, fcfg, input win, sel_t, sel_f);
endinterface : ebu_win_if

// *** ebu_win_dec.sv ***
/*
 * Address window decoder: picks the window that owns an address and its
 * timing and function settings.
 * Assumes a caller that latches the result; the decoder itself is purely combinational.
 */
module ebu_win_dec
    import ebu_pkg::*;
(
    ebu_win_if.dec wif
);

    // Higher windows are tested last so they override lower ones.
    always_comb begin
        wif.win   = WIN_DEFAULT;
        wif.sel_t = wif.tcfg[0];
        wif.sel_f = wif.fcfg[0];
        for (int i = 0; i < WIN_NUM; i++) begin
            if (ebu_win_hit(wif.addr, wif.asel[i])) begin
                wif.win   = 3'(i + 1);
                wif.sel_t = wif.tcfg[i + 1];
                wif.sel_f = wif.fcfg[i + 1];
            end
        end
    end

endmodule : ebu_win_dec

// *** ebu_top.sv ***
/*
 * External bus unit: carries CPU accesses to external memories over a
 * programmable parallel bus and to on-chip modules over the peripheral bus.
 * Assumes one outstanding CPU request, configuration held stable while busy,
 * and external pins resolved from the output enables by the surroundings.
 */
// Notes on behaviour
// - Every external access goes through this unit and nothing else drives the pins.
// - Peripheral bus addresses go over the peripheral bus with no strobe, chip select or address latch enable; driven segment lines still show the address.
// - Single-chip mode keeps the external bus quiet; only the reference clock out keeps running.
// - External address width is programmable from zero to 24 bits.
// - Data bus width is 8 or 16 bits per region.
// - Multiplexed and demultiplexed bus operation are both supported.
// - Address and data share one port; demux adds a separate low address port.
// - Segment address lines in use are selectable; unused lines are released.
// - Up to four chip-select outputs, for windows and the default region.
// - Bus timing comes from the configuration of the selected region.
// - A ready input stretches accesses; its asserted level is programmable.
// - Four address windows each give their range own bus characteristics.
// - Overlapping windows: higher window number wins.
// - Addresses outside all windows use the default region settings.
// - The selected window drives its own chip select, except window 4, which has none.
// - The address phase starts at acceptance; later bus phases change on rising edges of the reference clock out.
// - Bus mode is chosen per access from the addressed window.
// - External I/O area writes are never posted; accesses stay in order.
module ebu_top
    import ebu_pkg::*;
#(
    parameter int REF_HALF = 1
) (
    input  logic                     clk_sys_i,
    input  logic                     reset_n_i,
    input  logic                     cpu_req_i,
    input  logic [ADDR_W-1:0]        cpu_addr_i,
    input  logic                     cpu_we_i,
    input  logic [DATA_W-1:0]        cpu_wdata_i,
    output logic                     cpu_rdy_o,
    output logic                     cpu_ack_o,
    output logic                     cpu_err_o,
    output logic [DATA_W-1:0]        cpu_rdata_o,
    output logic                     per_req_o,
    output logic [ADDR_W-1:0]        per_addr_o,
    output logic                     per_we_o,
    output logic [DATA_W-1:0]        per_wdata_o,
    input  logic [DATA_W-1:0]        per_rdata_i,
    input  logic                     per_ack_i,
    input  logic                     single_chip_i,
    input  logic [AW_W-1:0]          addr_width_i,
    input  ebu_asel_s [WIN_NUM-1:0]  window_address_select_i,
    input  ebu_tcfg_s [WIN_NUM-1:0]  window_timing_config_i,
    input  ebu_fcfg_s [WIN_NUM-1:0]  window_function_config_i,
    input  ebu_tcfg_s                default_timing_config_i,
    input  ebu_fcfg_s                default_function_config_i,
    output logic                     bus_reference_clock_out_o,
    output logic                     ale_o,
    output logic                     rd_n_o,
    output logic                     wr_n_o,
    output logic [CS_NUM-1:0]        cs_n_o,
    output logic [DATA_W-1:0]        ad_o,
    input  logic [DATA_W-1:0]        ad_i,
    output logic                     ad_oe_n_o,
    output logic [SEG_LSB-1:0]       lo_addr_o,
    output logic [SEG_LSB-1:0]       lo_addr_oe_n_o,
    output logic [SEG_W-1:0]         seg_addr_o,
    output logic [SEG_W-1:0]         seg_oe_n_o,
    input  logic                     ready_pin_i
);

    localparam int DIV_W = $clog2(REF_HALF + 1);

    ebu_state_e         state_ff;
    logic [CNT_W-1:0]   cnt_ff;
    logic               half_ff;
    logic               posted_ff;
    logic               ack_ff;
    logic               err_ff;
    logic [DATA_W-1:0]  rdata_ff;
    logic [ADDR_W-1:0]  addr_ff;
    logic               we_ff;
    logic [DATA_W-1:0]  wdata_ff;
    logic [2:0]         win_ff;
    ebu_tcfg_s          tcfg_ff;
    ebu_fcfg_s          fcfg_ff;
    logic [DIV_W-1:0]   div_ff;
    logic               ref_ff;
    logic               rdy_s1_ff;
    logic               rdy_s2_ff;
    logic [DATA_W-1:0]  ad_s1_ff;
    logic [DATA_W-1:0]  ad_s2_ff;
    logic               ref_rise;
    logic               is_peri;
    logic               is_io;
    logic               rdy_ok;
    logic               phase_done;
    logic               in_bus;
    logic               strobe;
    logic               data_phase;
    logic [ADDR_W-1:0]  bus_addr;
    logic [ADDR_W-1:0]  addr_mask;

    ebu_win_if wif ();

    // The decoder sees the live request so the region is known at acceptance.
    assign wif.addr = cpu_addr_i;
    assign wif.asel = window_address_select_i;
    assign wif.tcfg = {window_timing_config_i, default_timing_config_i};
    assign wif.fcfg = {window_function_config_i, default_function_config_i};

    ebu_win_dec u_win_dec (
        .wif (wif.dec)
    );

    // Reference clock divider; phases advance only where its rising edge falls.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            div_ff <= '0;
            ref_ff <= 1'b0;
        end else if (div_ff == DIV_W'(REF_HALF - 1)) begin
            div_ff <= '0;
            ref_ff <= ~ref_ff;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    assign ref_rise = (div_ff == DIV_W'(REF_HALF - 1)) && !ref_ff;
    assign bus_reference_clock_out_o = ref_ff;

    // Pin inputs cross into the system clock through two flip-flops.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rdy_s1_ff <= 1'b0;
            rdy_s2_ff <= 1'b0;
            ad_s1_ff  <= '0;
            ad_s2_ff  <= '0;
        end else begin
            rdy_s1_ff <= ready_pin_i;
            rdy_s2_ff <= rdy_s1_ff;
            ad_s1_ff  <= ad_i;
            ad_s2_ff  <= ad_s1_ff;
        end
    end

    // Region classification of the incoming request.
    assign is_peri = (cpu_addr_i >= PERI_LO) && (cpu_addr_i < IO_LO);
    assign is_io   = (cpu_addr_i >= IO_LO) && (cpu_addr_i <= IO_HI);

    // Ready compares against the programmed level of the selected region.
    assign rdy_ok = rdy_s2_ff == fcfg_ff.rdy_pol;
    assign phase_done = ref_rise &&
        ((state_ff == ST_CMD && cnt_ff == '0 && !fcfg_ff.rdy_en) ||
         (state_ff == ST_RDY && rdy_ok));

    // Access sequencer; external bus writes outside the I/O area are acknowledged early.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_ff  <= ST_IDLE;
            cnt_ff    <= '0;
            half_ff   <= 1'b0;
            posted_ff <= 1'b0;
            ack_ff    <= 1'b0;
            err_ff    <= 1'b0;
            rdata_ff  <= '0;
            addr_ff   <= '0;
            we_ff     <= 1'b0;
            wdata_ff  <= '0;
            win_ff    <= WIN_DEFAULT;
            tcfg_ff   <= '0;
            fcfg_ff   <= '0;
        end else begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    if (cpu_req_i) begin
                        addr_ff   <= cpu_addr_i;
                        we_ff     <= cpu_we_i;
                        wdata_ff  <= cpu_wdata_i;
                        half_ff   <= 1'b0;
                        posted_ff <= 1'b0;
                        win_ff    <= wif.win;
                        tcfg_ff   <= wif.sel_t;
                        fcfg_ff   <= wif.sel_f;
                        if (is_peri) begin
                            state_ff <= ST_PERI;
                        end else if (single_chip_i) begin
                            ack_ff <= 1'b1;
                            err_ff <= 1'b1;
                        end else begin
                            state_ff  <= ST_ADDR;
                            cnt_ff    <= CNT_W'(wif.sel_t.setup);
                            posted_ff <= cpu_we_i && !is_io;
                            ack_ff    <= cpu_we_i && !is_io;
                        end
                    end
                end
                ST_PERI: begin
                    if (per_ack_i) begin
                        state_ff <= ST_IDLE;
                        ack_ff   <= 1'b1;
                        if (!we_ff) begin
                            rdata_ff <= per_rdata_i;
                        end
                    end
                end
                ST_ADDR: begin
                    if (ref_rise && cnt_ff == '0) begin
                        state_ff <= ST_CMD;
                        cnt_ff   <= tcfg_ff.cmd;
                    end else if (ref_rise) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                ST_CMD: begin
                    if (ref_rise && cnt_ff == '0 && fcfg_ff.rdy_en) begin
                        state_ff <= ST_RDY;
                    end else if (ref_rise && cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                ST_RDY: begin
                    // Leaving this state is handled by the phase end below.
                end
                ST_HOLD: begin
                    if (ref_rise && cnt_ff == '0) begin
                        if (!fcfg_ff.bus16 && !half_ff) begin
                            half_ff  <= 1'b1;
                            state_ff <= ST_ADDR;
                            cnt_ff   <= CNT_W'(tcfg_ff.setup);
                        end else begin
                            state_ff <= ST_IDLE;
                            ack_ff   <= !posted_ff;
                        end
                    end else if (ref_rise) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
            // End of the command phase: sample read data and enter hold.
            if (phase_done) begin
                state_ff <= ST_HOLD;
                cnt_ff   <= CNT_W'(tcfg_ff.hold);
                if (!we_ff && fcfg_ff.bus16) begin
                    rdata_ff <= ad_s2_ff;
                end else if (!we_ff && half_ff) begin
                    rdata_ff[DATA_W-1:BYTE_W] <= ad_s2_ff[BYTE_W-1:0];
                end else if (!we_ff) begin
                    rdata_ff[BYTE_W-1:0] <= ad_s2_ff[BYTE_W-1:0];
                end
            end
        end
    end

    assign cpu_rdy_o   = state_ff == ST_IDLE;
    assign cpu_ack_o   = ack_ff;
    assign cpu_err_o   = err_ff;
    assign cpu_rdata_o = rdata_ff;

    // Peripheral bus request stands until the module acknowledges.
    assign per_req_o   = state_ff == ST_PERI;
    assign per_addr_o  = addr_ff;
    assign per_we_o    = we_ff;
    assign per_wdata_o = wdata_ff;

    // Address lines beyond the programmed width are released, or driven low on the shared port in mux mode.
    always_comb begin
        for (int i = 0; i < ADDR_W; i++) begin
            addr_mask[i] = addr_width_i > AW_W'(i);
        end
    end

    // Bus phase decode, all from registered state.
    assign in_bus = (state_ff == ST_ADDR) || (state_ff == ST_CMD) ||
                    (state_ff == ST_RDY) || (state_ff == ST_HOLD);
    assign strobe = (state_ff == ST_CMD) || (state_ff == ST_RDY);
    assign data_phase = we_ff && in_bus &&
                        (state_ff != ST_ADDR || !fcfg_ff.mux);
    assign bus_addr = {addr_ff[ADDR_W-1:1], addr_ff[0] | half_ff};

    assign ale_o  = (state_ff == ST_ADDR) && fcfg_ff.mux;
    assign rd_n_o = !(strobe && !we_ff);
    assign wr_n_o = !(strobe && we_ff);

    // Window 4 has no chip select of its own; default region uses line 0.
    always_comb begin
        for (int c = 0; c < CS_NUM; c++) begin
            cs_n_o[c] = !(in_bus && fcfg_ff.cs_en && win_ff != WIN_NO_CS &&
                          win_ff[1:0] == 2'(c));
        end
    end

    // Shared address/data port: address first in mux mode, then data.
    always_comb begin
        ad_o      = '0;
        ad_oe_n_o = 1'b1;
        if (state_ff == ST_ADDR && fcfg_ff.mux) begin
            ad_o      = bus_addr[SEG_LSB-1:0] & addr_mask[SEG_LSB-1:0];
            ad_oe_n_o = 1'b0;
        end else if (data_phase && fcfg_ff.bus16) begin
            ad_o      = wdata_ff;
            ad_oe_n_o = 1'b0;
        end else if (data_phase) begin
            ad_o[BYTE_W-1:0] = half_ff ? wdata_ff[DATA_W-1:BYTE_W]
                                       : wdata_ff[BYTE_W-1:0];
            ad_oe_n_o = 1'b0;
        end
    end

    // Demultiplexed low address port and segment lines.
    assign lo_addr_o      = bus_addr[SEG_LSB-1:0];
    assign lo_addr_oe_n_o = ~(addr_mask[SEG_LSB-1:0] &
                              {SEG_LSB{in_bus && !fcfg_ff.mux}});
    assign seg_addr_o     = bus_addr[ADDR_W-1:SEG_LSB];
    assign seg_oe_n_o     = ~(addr_mask[ADDR_W-1:SEG_LSB] &
                              {SEG_W{!single_chip_i}});

    // Checks on the sequencer and the pins it drives.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    AST_SINGLE_QUIET: assert property (
        cpu_req_i && cpu_rdy_o && single_chip_i && !is_peri
        |=> cpu_ack_o && cpu_err_o && cpu_rdy_o && rd_n_o && wr_n_o)
        else $error("single-chip access reached the bus");
    AST_PERI_NO_PINS: assert property (
        per_req_o |-> (&cs_n_o) && rd_n_o && wr_n_o && !ale_o)
        else $error("peripheral access moved external pins");
    AST_CS_HELD: assert property (
        in_bus && fcfg_ff.cs_en && win_ff == WIN_DEFAULT |-> !cs_n_o[0])
        else $error("default chip select dropped during access");
    AST_REF_EDGE: assert property (
        in_bus && $changed(state_ff) && $past(state_ff) != ST_IDLE
        |-> $past(ref_rise))
        else $error("bus phase changed off reference edge");
    AST_RDY_WAIT: assert property (
        state_ff == ST_RDY && !rdy_ok |=> state_ff == ST_RDY)
        else $error("ready wait left without ready");
    AST_RDY_DONE: assert property (
        state_ff == ST_RDY && ref_rise && rdy_ok |=> state_ff == ST_HOLD)
        else $error("asserted ready did not end the wait");
    AST_ALE_MUX: assert property (
        ale_o |-> fcfg_ff.mux && state_ff == ST_ADDR && (&lo_addr_oe_n_o))
        else $error("address latch enable outside mux address phase");
    AST_IO_NO_POST: assert property (
        cpu_req_i && cpu_rdy_o && cpu_we_i && is_io && !single_chip_i
        |=> !cpu_ack_o ##1 !cpu_ack_o)
        else $error("I/O area write was posted");
    AST_SEG_FREE: assert property (
        addr_width_i <= AW_W'(SEG_LSB) |-> &seg_oe_n_o)
        else $error("segment line driven beyond address width");
    AST_STROBE_CS: assert property (
        !rd_n_o && fcfg_ff.cs_en && win_ff != WIN_NO_CS |-> !(&cs_n_o))
        else $error("strobe without chip select");

    COV_READY_READ: cover property (
        state_ff == ST_RDY && !we_ff ##1 state_ff == ST_HOLD);
    COV_BYTE_SPLIT: cover property (
        half_ff && state_ff == ST_ADDR && !fcfg_ff.bus16);
    COV_PERI: cover property (per_req_o && per_ack_i);
    COV_POSTED: cover property (cpu_ack_o && in_bus && we_ff);

endmodule : ebu_top

// *** ebu_ext_mem.sv ***
/*
 * Behavioural external memory for the bus unit bench: 256 words and a ready delay.
 * Assumes it shares the system clock and sees the unit's strobes and address pins.
 */
module ebu_ext_mem (
    input  logic        clk_i,
    input  logic [3:0]  cs_n_i,
    input  logic        ale_i,
    input  logic        rd_n_i,
    input  logic        wr_n_i,
    input  logic [15:0] ad_i,
    input  logic [15:0] lo_addr_i,
    input  logic        rdy_pol_i,
    input  logic [7:0]  waits_i,
    output logic [15:0] ad_o,
    output logic        ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [256];
    logic [15:0] lat;
    logic [15:0] last   = 16'h0000;
    logic        mux_ff = 1'b0;
    logic [7:0]  cnt    = 8'h00;
    wire  [7:0]  idx    = mux_ff ? lat[7:0] : lo_addr_i[7:0];
    // Latch a multiplexed address; forget it once the bus is idle again.
    always @(posedge clk_i) begin
        if (ale_i) begin
            lat <= ad_i;
            mux_ff <= 1'b1;
        end else if (cs_n_i == 4'hF && rd_n_i && wr_n_i) begin
            mux_ff <= 1'b0;
        end
        if (!wr_n_i) mem[idx] <= ad_i;
        cnt <= (!rd_n_i || !wr_n_i) ? cnt + 8'h01 : 8'h00;
        if (!rd_n_i) last <= mem[idx];
    end
    // Released lines show the inverse of the last word, so stale data never matches.
    assign ad_o = !rd_n_i ? mem[idx] : ~last;
    // Ready is held off for waits_i cycles of a strobe, then shows its asserted level.
    assign ready_o = (cnt >= waits_i) ? rdy_pol_i : ~rdy_pol_i;
endmodule : ebu_ext_mem

// *** tb_top.sv ***
/*
 * Self-checking bench of the external bus unit with a memory model on its pins.
 * Assumes a 10 MHz system clock and a reference clock of eight system cycles.
 */
module tb_top
    import ebu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RH = 4;
    logic clk_sys_i = 0, reset_n_i = 0, cpu_req_i = 0, cpu_we_i = 0, single_chip_i = 0;
    logic [ADDR_W-1:0] cpu_addr_i = '0;
    logic [DATA_W-1:0] cpu_wdata_i = '0, per_rdata_i = '0;
    logic per_ack_i = 0, rpol = 0, ale_hit, re;
    logic [AW_W-1:0] addr_width_i = 5'h18;
    ebu_asel_s [WIN_NUM-1:0] asel;
    ebu_tcfg_s [WIN_NUM-1:0] tcfg;
    ebu_fcfg_s [WIN_NUM-1:0] fcfg;
    ebu_tcfg_s dtcfg;
    ebu_fcfg_s dfcfg;
    logic cpu_rdy_o, cpu_ack_o, cpu_err_o, per_req_o, refclk, ale_o, rd_n_o, wr_n_o;
    logic ad_oe_n_o, rdy_pin, per_we;
    logic [3:0] cs_n_o, cs_seen;
    logic [15:0] cpu_rdata_o, ad_o, ad_i, lo_addr_o, lo_oe_n, rq, per_wd;
    logic [23:0] per_addr_o;
    logic [7:0] seg_oe_n_o, seg_a, waits = 8'h00;
    int bad_count = 0, comparisons = 0, rn, nrd, n0;

    ebu_top #(.REF_HALF(RH)) i_ebu_top (
        .clk_sys_i, .reset_n_i, .cpu_req_i, .cpu_addr_i, .cpu_we_i, .cpu_wdata_i,
        .cpu_rdy_o, .cpu_ack_o, .cpu_err_o, .cpu_rdata_o, .per_req_o, .per_addr_o,
        .per_we_o(per_we), .per_wdata_o(per_wd), .per_rdata_i, .per_ack_i, .single_chip_i,
        .addr_width_i, .window_address_select_i(asel), .window_timing_config_i(tcfg),
        .window_function_config_i(fcfg), .default_timing_config_i(dtcfg),
        .default_function_config_i(dfcfg), .bus_reference_clock_out_o(refclk),
        .ale_o, .rd_n_o, .wr_n_o, .cs_n_o, .ad_o, .ad_i, .ad_oe_n_o, .lo_addr_o,
        .lo_addr_oe_n_o(lo_oe_n), .seg_addr_o(seg_a), .seg_oe_n_o, .ready_pin_i(rdy_pin)
    );
    ebu_ext_mem i_ebu_ext_mem (
        .clk_i(clk_sys_i), .cs_n_i(cs_n_o), .ale_i(ale_o), .rd_n_i(rd_n_o),
        .wr_n_i(wr_n_o), .ad_i(ad_o), .lo_addr_i(lo_addr_o), .rdy_pol_i(rpol),
        .waits_i(waits), .ad_o(ad_i), .ready_o(rdy_pin)
    );

    // The system clock toggles every half period of 50 ns.
    initial forever #50 clk_sys_i = ~clk_sys_i;
    // Remember the active select pattern, address latch pulses and read strobes.
    always @(posedge clk_sys_i) begin
        if (cs_n_o !== 4'hF) cs_seen <= cs_n_o;
        if (ale_o === 1'b1) ale_hit <= 1'b1;
        if ($fell(rd_n_o)) nrd <= nrd + 1;
    end
    // The peripheral bus answers in the first cycle of a request, with data derived from the address.
    always @(posedge clk_sys_i) begin
        #1;
        per_ack_i = per_req_o && !per_ack_i;
        per_rdata_i = per_addr_o[15:0] ^ 16'hA5A5;
    end
    // A hang ends the run through the same verdict as a normal finish.
    initial begin
        #3000000;
        bad_count++;
        test_done();
    end

    task automatic step();
        @(posedge clk_sys_i);
        #1;
    endtask : step
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One CPU access; the address is left on the port since decoding is live.
    task automatic acc(input logic [23:0] a, input logic w, input logic [15:0] d);
        step();  // An edge always passes, so the request never drops and rises at once.
        while (cpu_rdy_o !== 1'b1) step();
        cs_seen = 4'hF;
        ale_hit = 1'b0;
        nrd = 0;
        cpu_req_i = 1'b1;
        cpu_addr_i = a;
        cpu_we_i = w;
        cpu_wdata_i = d;
        step();
        cpu_req_i = 1'b0;
        rn = 1;
        while (cpu_ack_o !== 1'b1) begin
            step();
            rn++;
        end
        rq = cpu_rdata_o;
        re = cpu_err_o;
    endtask : acc
    task automatic t_seg();
        addr_width_i = 5'h14;
        step();
        chk(seg_oe_n_o, 8'hF0);
        addr_width_i = 5'h00;
        step();
        chk(seg_oe_n_o, 8'hFF);
        addr_width_i = 5'h18;
        step();
        chk(seg_oe_n_o, 8'h00);
        $display("Test seg done");
    endtask : t_seg
    task automatic t_single();
        single_chip_i = 1'b1;
        acc(24'h00_0040, 1'b0, 16'h0000);
        chk({re, cs_seen, seg_oe_n_o}, {1'b1, 4'hF, 8'hFF});
        acc(24'h20_0010, 1'b0, 16'h0000);
        chk({re, rq}, {1'b0, 16'hA5B5});
        acc(24'h20_0010, 1'b1, 16'h7777);
        chk({re, per_we, per_wd}, {1'b0, 1'b1, 16'h7777});
        single_chip_i = 1'b0;
        $display("Test single done");
    endtask : t_single
    task automatic t_default();
        acc(24'h00_0010, 1'b1, 16'h1234);
        chk(rn <= 2, 1);
        acc(24'h00_0010, 1'b0, 16'h0000);
        chk(rq, 16'h1234);
        chk({cs_seen, ale_hit, nrd[3:0]}, {4'hE, 1'b0, 4'h1});
        acc(24'h20_6000, 1'b1, 16'h5A5A);
        chk(rn >= 16, 1);
        acc(24'h20_6000, 1'b0, 16'h0000);
        chk(rq, 16'h5A5A);
        $display("Test default done");
    endtask : t_default
    task automatic t_win();
        acc(24'h01_0030, 1'b1, 16'hC3C3);
        acc(24'h01_0030, 1'b0, 16'h0000);
        chk(rq, 16'hC3C3);
        chk({cs_seen, ale_hit}, {4'hB, 1'b1});
        chk(seg_a, 8'h01);
        acc(24'h00_0010, 1'b0, 16'h0000);
        chk({rq, ale_hit}, {16'h1234, 1'b0});
        $display("Test window done");
    endtask : t_win
    task automatic t_ready();
        for (int p = 0; p < 2; p++) begin
            rpol = p[0];
            fcfg[2].rdy_pol = p[0];
            waits = 8'h00;
            acc(24'h02_0050, 1'b1, 16'h0F0F);
            acc(24'h02_0050, 1'b0, 16'h0000);
            n0 = rn;
            waits = 8'h28;
            acc(24'h02_0050, 1'b0, 16'h0000);
            chk({rq, cs_seen}, {16'h0F0F, 4'h7});
            // The baseline strobe already spans two reference periods of the forty cycles.
            chk(rn >= n0 + 24 && rn <= n0 + 40, 1);
        end
        $display("Test ready done");
    endtask : t_ready
    task automatic t_byte();
        acc(24'h03_0070, 1'b1, 16'hBEEF);
        acc(24'h03_0070, 1'b0, 16'h0000);
        chk(rq, 16'hBEEF);
        chk({cs_seen, nrd[3:0]}, {4'hF, 4'h2});
        $display("Test byte done");
    endtask : t_byte
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    // Windows 1 and 2 share one page, 3 has ready, 4 is an 8-bit region.
    initial begin
        asel = 64'h0300_0200_0100_0100;
        tcfg = '0;
        dtcfg = '0;
        fcfg = 20'h2_34E7;
        dfcfg = 5'h05;
        repeat (16) step();
        chk({cs_n_o, rd_n_o, wr_n_o, ad_oe_n_o, cpu_rdy_o, cpu_ack_o, refclk}, 10'h3FC);
        chk(lo_oe_n, 16'hFFFF);
        reset_n_i = 1'b1;
        t_seg();
        t_single();
        t_default();
        t_win();
        t_ready();
        t_byte();
        test_done();
    end
endmodule : tb_top
